// *** slave_wd_map.svh ***
// Register offsets, reset values and timing counts of the output watchdog.
// Assumes a 200 MHz system clock and a 16-bit register port.
`ifndef SLAVE_WD_MAP_SVH
`define SLAVE_WD_MAP_SVH

`define OFS_PRESCALE_MULT 12'h0400
`define OFS_LOCAL_WD_TIME 12'h0410
`define OFS_SYNC_WD_TIME 12'h0420
`define OFS_WD_STATUS 12'h0430

`define RST_PRESCALE_MULT 16'h09c2
`define RST_LOCAL_WD_TIME 16'h03e8
`define RST_SYNC_WD_TIME 16'h03e8

// Status word field positions
`define STS_SYNC_EXP 0
`define STS_LOCAL_EXP 1
`define STS_STATE_LSB 4

// One base period of the 25 MHz local clock, counted in system clocks
`define CLK_PERIOD_NS 5
`define BASE_PERIOD_NS 40
`define BASE_CYCLES ((`BASE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Base periods beyond the multiplier value in one watchdog tick
`define TICK_EXTRA 2

// State codes as seen on the request and status ports
`define CODE_INIT 4'h1
`define CODE_PREOP 4'h2
`define CODE_UPDATE 4'h3
`define CODE_GUARD 4'h4
`define CODE_RUN 4'h8

`endif

// *** slave_wd_pkg.sv ***
// Types shared by the watchdog and slave state logic.
// Assumes slave_wd_map.svh for the numbers.
package slave_wd_pkg;

	typedef enum logic [2:0] {
		st_initial,
		st_preparatory,
		st_guarded,
		st_running,
		st_update
	} slave_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [3:0] code;
	} state_req_t;

	typedef struct packed {
		logic mailbox_ok;
		logic process_ok;
		logic clock_sync_ok;
	} config_check_t;

endpackage : slave_wd_pkg

// *** comm_watchdog.sv ***
// One communication watchdog counting shared ticks since the last kick.
// Assumes tick is a single-cycle pulse from the common prescaler.
`timescale 1ns/1ps
`include "slave_wd_map.svh"

module comm_watchdog #(
	parameter int TIME_W = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Events
	input wire logic tick,
	input wire logic kick,
	input wire logic [TIME_W-1:0] limit,
	// State
	output logic expired
);

	logic [TIME_W-1:0] count;
	logic [TIME_W-1:0] next_count;
	logic next_expired;

	always_comb begin
		next_count = count;
		next_expired = expired;
		if (kick) begin
			// A kick restarts the count ahead of the zero-limit check
			next_count = '0; // see RL2
			next_expired = 1'b0;
		end else if (limit == '0) begin
			// Zero limit switches the watchdog off completely
			next_count = '0; // see RL9
			next_expired = 1'b0;
		end else if (tick && !expired) begin
			if (count + 1'b1 >= limit) begin
				next_expired = 1'b1; // see RL5
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	kick_clears_a: assert property (kick |=> !expired) // see RL2
		else $error("watchdog still expired after a kick");
	zero_disables_a: assert property (
		(limit == '0) ##1 (limit == '0) |-> !expired) // see RL9
		else $error("watchdog expired while disabled");
	expire_cause_a: assert property (
		$rose(expired) |-> $past(tick) && !$past(kick)) // see RL5
		else $error("watchdog expired without a tick");

endmodule : comm_watchdog

// *** fieldbus_slave_output_watchdog.sv ***
// Output safety of a fieldbus slave: shared prescaler, two watchdogs,
// slave state machine and the gated output register.
// Assumes register, request and access strobes synchronous to clk_sys.
`timescale 1ns/1ps
`include "slave_wd_map.svh"

// What this block does
// RL1: Two independent watchdogs, both default 100 ms
// RL2: Only bus process data access restarts sync watchdog
// RL3: Sync expiry clears outputs, state stays unchanged
// RL4: Local watchdog fires on idle local interface
// RL5: Shared tick, separate timer setting per watchdog
// RL6: Tick equals multiplier plus two 40 ns periods
// RL7: Multiplier resets to 2498, timers to 1000
// RL8: Timer 0..65535, multiplier 1..65535
// RL9: Sync timer zero disables that watchdog
// RL10: Settings writable at any time, no configurator enable
// RL11: Five states, initial after reset, no traffic
// RL12: Master configures mailbox channels in initial state
// RL13: Mailbox setup checked entering preparatory state
// RL14: Preparatory allows mailbox, refuses process data
// RL15: Master configures process channels in preparatory
// RL16: Guarded entry checks, then snapshots inputs first
// RL17: Guarded: traffic allowed, inputs cycle, outputs safe
// RL18: Normal start-up settles in running state
// RL19: Running state copies master data to outputs
// RL20: Failed check keeps state, no acknowledge
module fieldbus_slave_output_watchdog #(
	parameter int OUT_W = 2,
	parameter int IN_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire slave_wd_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_ack,
	// State requests from the master and configuration checks
	input wire slave_wd_pkg::state_req_t state_req,
	input wire slave_wd_pkg::config_check_t cfg_check,
	output logic state_ack,
	output logic state_refused,
	output logic [3:0] state_code,
	output logic mailbox_enable,
	output logic process_enable,
	// Traffic strobes
	input wire logic bus_pd_access,
	input wire logic local_access,
	// Process data
	input wire logic [OUT_W-1:0] master_out,
	input wire logic [IN_W-1:0] field_in,
	output logic [OUT_W-1:0] out_pins,
	output logic [IN_W-1:0] input_buffer,
	// Watchdog state
	output logic sync_expired,
	output logic local_expired
);

	localparam int BASE_W = $clog2(`BASE_CYCLES + 1);
	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(`BASE_CYCLES - 1);
	// Allowed traffic per state: {mailbox, process data}
	function automatic logic [1:0] traffic_of(slave_wd_pkg::slave_state_t s);
		case (s)
			slave_wd_pkg::st_preparatory: traffic_of = 2'b10;
			slave_wd_pkg::st_guarded: traffic_of = 2'b11;
			slave_wd_pkg::st_running: traffic_of = 2'b11;
			slave_wd_pkg::st_update: traffic_of = 2'b10;
			default: traffic_of = 2'b00;
		endcase
	endfunction : traffic_of
	function automatic logic [3:0] code_of(slave_wd_pkg::slave_state_t s);
		case (s)
			slave_wd_pkg::st_preparatory: code_of = `CODE_PREOP;
			slave_wd_pkg::st_guarded: code_of = `CODE_GUARD;
			slave_wd_pkg::st_running: code_of = `CODE_RUN;
			slave_wd_pkg::st_update: code_of = `CODE_UPDATE;
			default: code_of = `CODE_INIT;
		endcase
	endfunction : code_of

	// Registers
	logic [15:0] prescale_mult;
	logic [15:0] local_wd_time;
	logic [15:0] sync_wd_time;
	logic [15:0] next_prescale_mult;
	logic [15:0] next_local_wd_time;
	logic [15:0] next_sync_wd_time;
	logic [15:0] next_reg_rdata;
	logic next_reg_ack;
	logic sync_exp_raw;
	logic local_exp_raw;
	always_comb begin
		next_prescale_mult = prescale_mult;
		next_local_wd_time = local_wd_time;
		next_sync_wd_time = sync_wd_time;
		next_reg_rdata = 16'h0000;
		next_reg_ack = reg_req.wr | reg_req.rd;
		if (reg_req.wr) begin
			case (reg_req.addr)
				`OFS_PRESCALE_MULT: begin
					// Zero is outside the multiplier range and is ignored
					if (reg_req.wdata != 16'h0000) begin
						next_prescale_mult = reg_req.wdata; // see RL8
					end
				end
				`OFS_LOCAL_WD_TIME: next_local_wd_time = reg_req.wdata;
				`OFS_SYNC_WD_TIME: next_sync_wd_time = reg_req.wdata; // see RL8
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				`OFS_PRESCALE_MULT: next_reg_rdata = prescale_mult;
				`OFS_LOCAL_WD_TIME: next_reg_rdata = local_wd_time;
				`OFS_SYNC_WD_TIME: next_reg_rdata = sync_wd_time;
				`OFS_WD_STATUS: begin
					next_reg_rdata[`STS_SYNC_EXP] = sync_exp_raw;
					next_reg_rdata[`STS_LOCAL_EXP] = local_exp_raw;
					next_reg_rdata[`STS_STATE_LSB +: 4] = state_code;
				end
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prescale_mult <= `RST_PRESCALE_MULT; // see RL7
			local_wd_time <= `RST_LOCAL_WD_TIME; // see RL1
			sync_wd_time <= `RST_SYNC_WD_TIME; // see RL1
			reg_rdata <= 16'h0000;
			reg_ack <= 1'b0;
		end else begin
			prescale_mult <= next_prescale_mult;
			local_wd_time <= next_local_wd_time;
			sync_wd_time <= next_sync_wd_time;
			reg_rdata <= next_reg_rdata;
			reg_ack <= next_reg_ack;
		end
	end

	// Shared prescaler: base periods of the local clock, then mult + 2
	logic [BASE_W-1:0] base_cnt;
	logic [16:0] pre_cnt;
	logic tick;
	logic [BASE_W-1:0] next_base_cnt;
	logic [16:0] next_pre_cnt;
	logic next_tick;
	always_comb begin
		next_base_cnt = base_cnt + 1'b1;
		next_pre_cnt = pre_cnt;
		next_tick = 1'b0;
		if (base_cnt == BASE_LAST) begin
			next_base_cnt = '0;
			// Multiplier changes take effect at once, the compare uses the current value
			if (pre_cnt >= {1'b0, prescale_mult} + 17'(`TICK_EXTRA - 1)) begin
				next_pre_cnt = 17'h0_0000; // see RL6
				next_tick = 1'b1;
			end else begin
				next_pre_cnt = pre_cnt + 17'h0_0001;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			base_cnt <= '0;
			pre_cnt <= 17'h0_0000;
			tick <= 1'b0;
		end else begin
			base_cnt <= next_base_cnt;
			pre_cnt <= next_pre_cnt;
			tick <= next_tick;
		end
	end

	// Slave state machine
	slave_wd_pkg::slave_state_t state;
	slave_wd_pkg::slave_state_t next_state;
	logic next_state_ack;
	logic next_state_refused;
	logic [IN_W-1:0] next_input_buffer;
	always_comb begin
		next_state = state;
		next_state_ack = 1'b0;
		next_state_refused = 1'b0;
		next_input_buffer = input_buffer;
		if (state == slave_wd_pkg::st_guarded ||
				state == slave_wd_pkg::st_running) begin
			next_input_buffer = field_in; // see RL17
		end
		if (state_req.valid) begin
			next_state_refused = 1'b1; // see RL20
			case (state_req.code)
				`CODE_INIT: begin
					next_state = slave_wd_pkg::st_initial;
					next_state_refused = 1'b0;
				end
				`CODE_PREOP: begin
					if (state == slave_wd_pkg::st_initial) begin
						if (cfg_check.mailbox_ok) begin
							next_state = slave_wd_pkg::st_preparatory; // see RL13
							next_state_refused = 1'b0;
						end
					end else if (state != slave_wd_pkg::st_update) begin
						next_state = slave_wd_pkg::st_preparatory;
						next_state_refused = 1'b0;
					end
				end
				`CODE_UPDATE: begin
					// Update state is reachable from the initial state only
					if (state == slave_wd_pkg::st_initial &&
							cfg_check.mailbox_ok) begin
						next_state = slave_wd_pkg::st_update;
						next_state_refused = 1'b0;
					end
				end
				`CODE_GUARD: begin
					if (state == slave_wd_pkg::st_preparatory) begin
						if (cfg_check.process_ok && cfg_check.clock_sync_ok) begin
							next_state = slave_wd_pkg::st_guarded; // see RL16
							next_input_buffer = field_in; // see RL16
							next_state_refused = 1'b0;
						end
					end else if (state == slave_wd_pkg::st_guarded ||
							state == slave_wd_pkg::st_running) begin
						next_state = slave_wd_pkg::st_guarded;
						next_state_refused = 1'b0;
					end
				end
				`CODE_RUN: begin
					// Master guarantees valid output data before asking
					if (state == slave_wd_pkg::st_guarded ||
							state == slave_wd_pkg::st_running) begin
						next_state = slave_wd_pkg::st_running; // see RL18
						next_state_refused = 1'b0;
					end
				end
				default: ;
			endcase
			next_state_ack = !next_state_refused; // see RL20
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= slave_wd_pkg::st_initial; // see RL11
			state_ack <= 1'b0;
			state_refused <= 1'b0;
			input_buffer <= '0;
		end else begin
			state <= next_state;
			state_ack <= next_state_ack;
			state_refused <= next_state_refused;
			input_buffer <= next_input_buffer;
		end
	end

	// Watchdogs; a bus access counts only while process data is allowed
	logic pd_kick;
	assign pd_kick = bus_pd_access & process_enable;
	comm_watchdog #(.TIME_W(16)) u_sync_wd (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.kick(pd_kick), // see RL2
		.limit(sync_wd_time),
		.expired(sync_exp_raw)
	);
	// Local watchdog also treats zero as off, matching the sync one
	comm_watchdog #(.TIME_W(16)) u_local_wd (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.kick(local_access),
		.limit(local_wd_time),
		.expired(local_exp_raw) // see RL4
	);

	// Registered state view and gated outputs
	logic [OUT_W-1:0] next_out_pins;
	logic [1:0] next_traffic;
	always_comb begin
		next_traffic = traffic_of(next_state); // see RL14
		next_out_pins = '0;
		if (state == slave_wd_pkg::st_running && !sync_exp_raw) begin
			next_out_pins = master_out; // see RL19
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_pins <= '0;
			mailbox_enable <= 1'b0;
			process_enable <= 1'b0;
			state_code <= `CODE_INIT;
			sync_expired <= 1'b0;
			local_expired <= 1'b0;
		end else begin
			out_pins <= next_out_pins; // see RL3
			mailbox_enable <= next_traffic[1];
			process_enable <= next_traffic[0];
			state_code <= code_of(next_state);
			sync_expired <= sync_exp_raw;
			local_expired <= local_exp_raw;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence enter_guarded_s;
		(state == slave_wd_pkg::st_preparatory) ##1
		(state == slave_wd_pkg::st_guarded);
	endsequence
	outputs_safe_a: assert property ( // see RL3
		(out_pins != '0) |->
		$past(state == slave_wd_pkg::st_running && !sync_exp_raw))
		else $error("outputs driven outside running or after expiry");
	expiry_keeps_state_a: assert property ( // see RL3
		$rose(sync_exp_raw) && !state_req.valid |=> $stable(state))
		else $error("state changed on watchdog expiry");
	initial_no_traffic_a: assert property ( // see RL11
		(state == slave_wd_pkg::st_initial) |->
		!mailbox_enable && !process_enable)
		else $error("traffic enabled in initial state");
	prep_no_pd_a: assert property ( // see RL14
		(state == slave_wd_pkg::st_preparatory) |->
		mailbox_enable && !process_enable)
		else $error("process data allowed in preparatory state");
	guard_snapshot_a: assert property ( // see RL16
		enter_guarded_s |-> input_buffer == $past(field_in))
		else $error("inputs not captured on guarded entry");
	failed_check_a: assert property ( // see RL20
		state_req.valid && state_req.code == `CODE_PREOP &&
		state == slave_wd_pkg::st_initial && !cfg_check.mailbox_ok |=>
		state == slave_wd_pkg::st_initial && !state_ack && state_refused)
		else $error("failed check still changed state");
	tick_spacing_a: assert property ( // see RL6
		tick |=> !tick [*8])
		else $error("watchdog ticks too close together");
	mult_reset_a: assert property ( // see RL7
		$fell(rst) |-> prescale_mult == `RST_PRESCALE_MULT &&
		sync_wd_time == `RST_SYNC_WD_TIME)
		else $error("watchdog settings wrong after reset");
	running_copy_a: assert property ( // see RL19
		state == slave_wd_pkg::st_running && !sync_exp_raw |=>
		out_pins == $past(master_out))
		else $error("running state did not copy master data");
endmodule : fieldbus_slave_output_watchdog

// *** master_model.sv ***
// Fieldbus master model: state requests, config checks, bus accesses.
// Assumes bench commands; every output is registered on clk_sys.
`timescale 1ns/1ps

module master_model #(
	parameter int OUT_W = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Commands from the bench
	input wire logic cmd_req,
	input wire logic [3:0] cmd_code,
	input wire logic [2:0] cmd_cfg,
	input wire logic cmd_pd,
	input wire logic [OUT_W-1:0] cmd_data,
	// Slave side
	output slave_wd_pkg::state_req_t state_req,
	output slave_wd_pkg::config_check_t cfg_check,
	output logic bus_pd_access,
	output logic [OUT_W-1:0] master_out
);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_req <= '0;
			cfg_check <= '0;
			bus_pd_access <= 1'b0;
		end else begin
			state_req <= '{cmd_req, cmd_code};
			// Channel setup outcome held as a level
			cfg_check <= slave_wd_pkg::config_check_t'(cmd_cfg);
			bus_pd_access <= cmd_pd;
		end
	end

	// Data stays valid before and across a running request
	always_ff @(posedge clk_sys) begin
		master_out <= cmd_data;
	end
endmodule : master_model

// *** testbench.sv ***
// Self-checking bench of the fieldbus slave output watchdog.
// Assumes the design files and master_model compiled before it.
`timescale 1ns/1ps
`include "slave_wd_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module testbench;
	typedef struct packed {
		logic [3:0] code;
		logic [2:0] cfg;
		logic ack;
		logic [3:0] st;
		logic mb;
		logic pd;
	} row_t;
	// Tick period once the multiplier is 1
	localparam int TP = (1 + `TICK_EXTRA) * `BASE_CYCLES;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	slave_wd_pkg::reg_req_t reg_req = '0;
	logic [15:0] reg_rdata;
	logic reg_ack;
	slave_wd_pkg::state_req_t state_req;
	slave_wd_pkg::config_check_t cfg_check;
	logic state_ack;
	logic state_refused;
	logic [3:0] state_code;
	logic mailbox_enable;
	logic process_enable;
	logic bus_pd_access;
	logic local_access = 1'b0;
	logic [1:0] master_out;
	logic [1:0] out_pins;
	logic [7:0] field_in = 8'ha5;
	logic [7:0] input_buffer;
	logic sync_expired;
	logic local_expired;
	logic cmd_req = 1'b0;
	logic [3:0] cmd_code = 4'h0;
	logic [2:0] cmd_cfg = 3'h0;
	logic cmd_pd = 1'b0;
	logic [1:0] cmd_data = 2'h3;
	int errors = 0;
	int checks = 0;
	int n;
	logic [15:0] rd;
	row_t rows [10];
	logic [27:0] regs [4];

	always #2.5 clk_sys = ~clk_sys;

	master_model #(.OUT_W(2)) partner (.clk_sys, .rst, .cmd_req,
		.cmd_code, .cmd_cfg, .cmd_pd, .cmd_data, .state_req,
		.cfg_check, .bus_pd_access, .master_out);

	fieldbus_slave_output_watchdog #(.OUT_W(2), .IN_W(8)) dut (.clk_sys,
		.rst, .reg_req, .reg_rdata, .reg_ack, .state_req, .cfg_check,
		.state_ack, .state_refused, .state_code, .mailbox_enable,
		.process_enable, .bus_pd_access, .local_access, .master_out,
		.field_in, .out_pins, .input_buffer, .sync_expired,
		.local_expired);

	task automatic complete_run;
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic reg_op(input logic w, input logic [11:0] a,
			input logic [15:0] d);
		int i;
		@(posedge clk_sys);
		reg_req <= '{w, ~w, a, d};
		@(posedge clk_sys);
		reg_req <= '0;
		#1;
		for (i = 0; i < 4 && reg_ack !== 1'b1; i++)
			@(posedge clk_sys) #1;
		if (i == 4) begin
			errors++;
			complete_run();
		end
		rd = reg_rdata;
	endtask : reg_op

	task automatic kick(input logic with_local);
		@(posedge clk_sys);
		cmd_pd <= 1'b1;
		local_access <= with_local;
		@(posedge clk_sys);
		cmd_pd <= 1'b0;
		local_access <= 1'b0;
	endtask : kick

	task automatic check_reset;
		`CHK("state", `CODE_INIT, state_code)
		`CHK("pd_en", 1'b0, process_enable)
		`CHK("mb_en", 1'b0, mailbox_enable)
		`CHK("out", 2'h0, out_pins)
		foreach (regs[i]) begin
			reg_op(1'b0, regs[i][27:16], 16'h0000);
			`CHK("reg", regs[i][15:0], rd)
		end
	endtask : check_reset

	initial begin
		regs = '{{`OFS_PRESCALE_MULT, `RST_PRESCALE_MULT},
			{`OFS_LOCAL_WD_TIME, `RST_LOCAL_WD_TIME},
			{`OFS_SYNC_WD_TIME, `RST_SYNC_WD_TIME}, {12'h440, 16'h0000}};
		rows = '{'{4'h5, 3'h7, 1'b0, `CODE_INIT, 1'b0, 1'b0},
			'{`CODE_UPDATE, 3'h4, 1'b1, `CODE_UPDATE, 1'b0, 1'b0},
			'{`CODE_PREOP, 3'h4, 1'b0, `CODE_UPDATE, 1'b0, 1'b0},
			'{`CODE_INIT, 3'h0, 1'b1, `CODE_INIT, 1'b0, 1'b0},
			'{`CODE_PREOP, 3'h0, 1'b0, `CODE_INIT, 1'b0, 1'b0},
			'{`CODE_RUN, 3'h7, 1'b0, `CODE_INIT, 1'b0, 1'b0},
			'{`CODE_PREOP, 3'h4, 1'b1, `CODE_PREOP, 1'b1, 1'b0},
			'{`CODE_GUARD, 3'h6, 1'b0, `CODE_PREOP, 1'b1, 1'b0},
			'{`CODE_GUARD, 3'h7, 1'b1, `CODE_GUARD, 1'b1, 1'b1},
			'{`CODE_RUN, 3'h7, 1'b1, `CODE_RUN, 1'b1, 1'b1}};
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		check_reset();
		// Multiplier written right after reset, zero first to check it is ignored
		reg_op(1'b1, `OFS_PRESCALE_MULT, 16'h0000);
		reg_op(1'b0, `OFS_PRESCALE_MULT, 16'h0000);
		`CHK("mult_zero", `RST_PRESCALE_MULT, rd)
		reg_op(1'b1, `OFS_PRESCALE_MULT, 16'h0001);
		reg_op(1'b0, `OFS_PRESCALE_MULT, 16'h0000);
		`CHK("mult", 16'h0001, rd)
		foreach (rows[i]) begin
			cmd_data <= 2'h3;
			@(posedge clk_sys);
			cmd_req <= 1'b1;
			cmd_code <= rows[i].code;
			cmd_cfg <= rows[i].cfg;
			@(posedge clk_sys);
			cmd_req <= 1'b0;
			@(posedge clk_sys) #1;
			`CHK("ack", rows[i].ack, state_ack)
			`CHK("refused", ~rows[i].ack, state_refused)
			`CHK("state", rows[i].st, state_code)
			`CHK("pd_en", rows[i].pd, process_enable)
			if (rows[i].st != `CODE_UPDATE)
				`CHK("mb_en", rows[i].mb, mailbox_enable)
			if (rows[i].st != `CODE_RUN)
				`CHK("out", 2'h0, out_pins)
			if (rows[i].ack && rows[i].st == `CODE_GUARD) begin
				`CHK("snapshot", 8'ha5, input_buffer)
				@(posedge clk_sys) field_in <= 8'h3c;
				@(posedge clk_sys) #1;
				`CHK("inputs", 8'h3c, input_buffer)
			end
		end
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("out_run", 2'h3, out_pins)
		reg_op(1'b1, `OFS_SYNC_WD_TIME, 16'h0002);
		reg_op(1'b1, `OFS_LOCAL_WD_TIME, 16'h0004);
		kick(1'b1);
		repeat (3) @(posedge clk_sys);
		// Local transfers alone must not hold off the sync watchdog
		for (n = 0; n < 3 * TP && sync_expired !== 1'b1; n++) begin
			@(posedge clk_sys);
			local_access <= (n % 10 == 0);
			#1;
		end
		`CHK("sync_time", 1'b1, n >= TP - 2 && n <= 2 * TP)
		if (n >= 3 * TP)
			complete_run();
		`CHK("sync_exp", 1'b1, sync_expired)
		`CHK("out_off", 2'h0, out_pins)
		`CHK("state_kept", `CODE_RUN, state_code)
		`CHK("local_held", 1'b0, local_expired)
		@(posedge clk_sys) local_access <= 1'b0;
		for (n = 0; n < 15; n++) begin
			kick(1'b0);
			repeat (8) @(posedge clk_sys);
			#1;
			if (n > 0)
				`CHK("sync_kept", 1'b0, sync_expired)
		end
		`CHK("out_back", 2'h3, out_pins)
		`CHK("local_exp", 1'b1, local_expired)
		reg_op(1'b0, `OFS_WD_STATUS, 16'h0000);
		`CHK("status", (16'(`CODE_RUN) << `STS_STATE_LSB) |
			(16'h0001 << `STS_LOCAL_EXP), rd)
		reg_op(1'b1, `OFS_SYNC_WD_TIME, 16'h0000);
		kick(1'b0);
		repeat (4 * TP) @(posedge clk_sys);
		#1;
		`CHK("sync_off", 1'b0, sync_expired)
		`CHK("out_kept", 2'h3, out_pins)
		@(posedge clk_sys) rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK("sync_rst", 1'b0, sync_expired)
		check_reset();
		complete_run();
	end
endmodule : testbench
